// [pkg/alert_mask_pkg.sv]
// constants for the charger alert enable masks
package alert_mask_pkg;

    // register port widths
    localparam int CMD_W    = 8;
    localparam int DATA_W   = 16;
    localparam int STATE_W  = 13;
    localparam int STATUS_W = 6;
    localparam int EVENT_W  = STATE_W + STATUS_W;

    // command codes
    localparam logic [CMD_W-1:0] CMD_STATE_EN  = 8'h0e;
    localparam logic [CMD_W-1:0] CMD_STATUS_EN = 8'h0f;

    // reset values and writable bits
    localparam logic [STATE_W-1:0]  STATE_EN_RESET  = 13'h0000;
    localparam logic [STATE_W-1:0]  STATE_EN_WMASK  = 13'h19ff;
    localparam logic [STATUS_W-1:0] STATUS_EN_RESET = 6'h00;
    localparam logic [STATUS_W-1:0] STATUS_EN_WMASK = 6'h3f;

    // charger state enable bit positions
    localparam int BIT_DETECT_FAIL    = 12;
    localparam int BIT_DETECT_TEST    = 11;
    localparam int BIT_RSVD_HI        = 10;
    localparam int BIT_RSVD_LO        = 9;
    localparam int BIT_SUSPENDED      = 8;
    localparam int BIT_PRECHARGE      = 7;
    localparam int BIT_BULK_PHASE     = 6;
    localparam int BIT_TEMP_PAUSE     = 5;
    localparam int BIT_CV_TIMEOUT     = 4;
    localparam int BIT_LOW_CURRENT    = 3;
    localparam int BIT_CHARGE_TIMEOUT = 2;
    localparam int BIT_MISSING        = 1;
    localparam int BIT_SHORT          = 0;

    // charge status enable bit positions
    localparam int BIT_SAFETY_LIMIT   = 5;
    localparam int BIT_THERMAL_LIMIT  = 4;
    localparam int BIT_INPUT_UV       = 3;
    localparam int BIT_INPUT_CURRENT  = 2;

endpackage

// [verilog/edge_alert_gate.sv]
// per-bit rising edge detector gated by an enable vector
`timescale 1ns/100ps
module edge_alert_gate
#(
    parameter int WIDTH = 19
)
(
    // clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // event levels and enables
    input  wire logic [WIDTH-1:0] level,
    input  wire logic [WIDTH-1:0] enable,
    // registered results
    output logic      [WIDTH-1:0] hit,
    output logic                  any_hit
);

    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_prev;
    logic [WIDTH-1:0] next_hit;
    logic             next_any_hit;

    generate
        if (WIDTH < 1)
        begin : g_bad_width
            $error("edge_alert_gate needs at least one event");
        end
    endgenerate

    // a bit fires only on a fresh rise while its enable is set
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            assign next_hit[i] = level[i] & ~prev[i] & enable[i];
        end
    endgenerate

    always_comb
    begin
        next_prev    = level;
        next_any_hit = |next_hit;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            prev    <= '0;
            hit     <= '0;
            any_hit <= 1'b0;
        end
        else
        begin
            prev    <= next_prev;
            hit     <= next_hit;
            any_hit <= next_any_hit;
        end
    end

endmodule

// [verilog/charger_alert_enable_masks.sv]
// alert enable masks for charger state and charge status events
//
// Summary of operation
// [RL1] state enable register, code 0x0E, bits 12:0, read/write, reset zero
// [RL2] state bit 12 enables alert on battery detection failure fault
// [RL3] state bit 11 enables alert on entering battery detection testing
// [RL4] state bit 8 enables alert on the suspended state
// [RL5] state bit 7 enables alert at onset of precharge
// [RL6] state bit 6 enables alert at onset of constant current/voltage phase
// [RL7] state bit 5 enables alert when charging pauses on thermistor range
// [RL8] state bit 4 enables alert on constant voltage time limit termination
// [RL9] state bit 3 enables alert on low current termination
// [RL10] state bit 2 enables alert on total charge time fault
// [RL11] state bit 1 enables alert on missing battery fault
// [RL12] state bit 0 enables alert on shorted battery fault
// [RL13] status enable register, code 0x0F, bits 5:0, read/write, reset zero
// [RL14] status bit 5 enables alert on safety current limit indication
// [RL15] status bit 4 enables alert while thermal regulation is active
// [RL16] status bit 3 enables alert when input undervoltage loop takes over
// [RL17] status bit 2 enables alert when input current loop takes over
// [RL18] alert only on new enabled rise; cleared enable mutes only its event
// [RL19] state bits 10:9 reserved: read zero, no alert effect
`timescale 1ns/100ps
module charger_alert_enable_masks
(
    // clock and reset
    input  wire logic                                clock,
    input  wire logic                                resetn,
    // register port
    input  wire logic [alert_mask_pkg::CMD_W-1:0]    reg_cmd,
    input  wire logic                                reg_write,
    input  wire logic [alert_mask_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                                reg_read,
    output logic      [alert_mask_pkg::DATA_W-1:0]   reg_rdata,
    output logic                                     reg_rvalid,
    output logic                                     reg_miss,
    // charger state event levels
    input  wire logic                                detect_failed_fault,
    input  wire logic                                detect_testing,
    input  wire logic                                suspended,
    input  wire logic                                precharge_phase,
    input  wire logic                                bulk_phase,
    input  wire logic                                temp_pause,
    input  wire logic                                cv_timeout_term,
    input  wire logic                                low_current_term,
    input  wire logic                                charge_timeout_fault,
    input  wire logic                                battery_missing_fault,
    input  wire logic                                battery_short_fault,
    // charge status event levels
    input  wire logic                                safety_limit_active,
    input  wire logic                                thermal_limit_active,
    input  wire logic                                input_uv_loop_active,
    input  wire logic                                input_current_loop_active,
    // alert request toward the bus side
    output logic                                     alert_request,
    output logic      [alert_mask_pkg::STATE_W-1:0]  state_alert_cause,
    output logic      [alert_mask_pkg::STATUS_W-1:0] status_alert_cause
);
    import alert_mask_pkg::*;

    logic [STATE_W-1:0]  state_en;
    logic [STATE_W-1:0]  next_state_en;
    logic [STATUS_W-1:0] status_en;
    logic [STATUS_W-1:0] next_status_en;
    logic [DATA_W-1:0]   next_rdata;
    logic                next_rvalid;
    logic                next_miss;
    logic [STATE_W-1:0]  state_level;
    logic [STATUS_W-1:0] status_level;
    logic [EVENT_W-1:0]  hit;

    // event vectors laid out like the enable registers
    always_comb
    begin
        state_level                     = '0;
        state_level[BIT_DETECT_FAIL]    = detect_failed_fault; // RL2
        state_level[BIT_DETECT_TEST]    = detect_testing; // RL3
        state_level[BIT_SUSPENDED]      = suspended; // RL4
        state_level[BIT_PRECHARGE]      = precharge_phase; // RL5
        state_level[BIT_BULK_PHASE]     = bulk_phase; // RL6
        state_level[BIT_TEMP_PAUSE]     = temp_pause; // RL7
        state_level[BIT_CV_TIMEOUT]     = cv_timeout_term; // RL8
        state_level[BIT_LOW_CURRENT]    = low_current_term; // RL9
        state_level[BIT_CHARGE_TIMEOUT] = charge_timeout_fault; // RL10
        state_level[BIT_MISSING]        = battery_missing_fault; // RL11
        state_level[BIT_SHORT]          = battery_short_fault; // RL12
        status_level                    = '0;
        status_level[BIT_SAFETY_LIMIT]  = safety_limit_active; // RL14
        status_level[BIT_THERMAL_LIMIT] = thermal_limit_active; // RL15
        status_level[BIT_INPUT_UV]      = input_uv_loop_active; // RL16
        status_level[BIT_INPUT_CURRENT] = input_current_loop_active; // RL17
    end

    // register writes and reads
    always_comb
    begin
        next_state_en  = state_en;
        next_status_en = status_en;
        next_rdata     = reg_rdata;
        next_rvalid    = 1'b0;
        next_miss      = 1'b0;
        if (reg_write)
        begin
            case (reg_cmd)
                CMD_STATE_EN:
                    next_state_en = reg_wdata[STATE_W-1:0]
                                  & STATE_EN_WMASK; // RL1 RL19
                CMD_STATUS_EN:
                    next_status_en = reg_wdata[STATUS_W-1:0]
                                   & STATUS_EN_WMASK; // RL13
                default:
                    next_miss = 1'b1;
            endcase
        end
        if (reg_read)
        begin
            next_rvalid = 1'b1;
            case (reg_cmd)
                CMD_STATE_EN:
                    next_rdata = {{(DATA_W-STATE_W){1'b0}}, state_en}; // RL1
                CMD_STATUS_EN:
                    next_rdata = {{(DATA_W-STATUS_W){1'b0}}, status_en}; // RL13
                default:
                begin
                    next_rdata = '0;
                    next_miss  = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            state_en   <= STATE_EN_RESET; // RL1
            status_en  <= STATUS_EN_RESET; // RL13
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
            reg_miss   <= 1'b0;
        end
        else
        begin
            state_en   <= next_state_en;
            status_en  <= next_status_en;
            reg_rdata  <= next_rdata;
            reg_rvalid <= next_rvalid;
            reg_miss   <= next_miss;
        end
    end

    // one shared edge gate, so the alert and causes share one flop stage
    edge_alert_gate
    #(
        .WIDTH (EVENT_W)
    )
    u_gate
    (
        .clock   (clock),
        .resetn  (resetn),
        .level   ({status_level, state_level}),
        .enable  ({status_en, state_en}), // RL18
        .hit     (hit),
        .any_hit (alert_request) // RL18
    );

    assign state_alert_cause  = hit[STATE_W-1:0];
    assign status_alert_cause = hit[EVENT_W-1:STATE_W];

    a_state_write : assert property ( // RL1
        @(posedge clock) disable iff (!resetn)
        reg_write && reg_cmd == CMD_STATE_EN
        |=> state_en == ($past(reg_wdata[STATE_W-1:0]) & STATE_EN_WMASK))
        else $error("state enable write not stored");

    a_status_read : assert property ( // RL13
        @(posedge clock) disable iff (!resetn)
        reg_read && reg_cmd == CMD_STATUS_EN && !reg_write
        |=> reg_rvalid && reg_rdata == {10'h000, status_en})
        else $error("status enable read wrong");

    a_detect_fail : assert property ( // RL2
        @(posedge clock) disable iff (!resetn)
        $rose(detect_failed_fault) && state_en[BIT_DETECT_FAIL]
        |=> alert_request && state_alert_cause[BIT_DETECT_FAIL])
        else $error("detect failure alert missing");

    a_detect_test : assert property ( // RL3
        @(posedge clock) disable iff (!resetn)
        $rose(detect_testing) && state_en[BIT_DETECT_TEST]
        ##1 1'b1 |-> alert_request && state_alert_cause[BIT_DETECT_TEST])
        else $error("detect testing alert missing");

    a_suspend_alert : assert property ( // RL4
        @(posedge clock) disable iff (!resetn)
        $rose(suspended) && state_en[BIT_SUSPENDED]
        |=> state_alert_cause[BIT_SUSPENDED])
        else $error("suspend alert missing");

    a_precharge_alert : assert property ( // RL5
        @(posedge clock) disable iff (!resetn)
        $rose(precharge_phase) && state_en[BIT_PRECHARGE]
        |=> alert_request && state_alert_cause[BIT_PRECHARGE])
        else $error("precharge alert missing");

    a_bulk_alert : assert property ( // RL6
        @(posedge clock) disable iff (!resetn)
        $rose(bulk_phase) && state_en[BIT_BULK_PHASE]
        |=> state_alert_cause[BIT_BULK_PHASE])
        else $error("bulk phase alert missing");

    a_pause_alert : assert property ( // RL7
        @(posedge clock) disable iff (!resetn)
        $rose(temp_pause) && state_en[BIT_TEMP_PAUSE]
        |=> alert_request && state_alert_cause[BIT_TEMP_PAUSE])
        else $error("temperature pause alert missing");

    a_cv_timeout : assert property ( // RL8
        @(posedge clock) disable iff (!resetn)
        $rose(cv_timeout_term) && state_en[BIT_CV_TIMEOUT]
        |=> state_alert_cause[BIT_CV_TIMEOUT])
        else $error("cv timeout alert missing");

    a_low_current : assert property ( // RL9
        @(posedge clock) disable iff (!resetn)
        $rose(low_current_term) && state_en[BIT_LOW_CURRENT]
        |=> state_alert_cause[BIT_LOW_CURRENT])
        else $error("low current alert missing");

    a_charge_timeout : assert property ( // RL10
        @(posedge clock) disable iff (!resetn)
        $rose(charge_timeout_fault) && state_en[BIT_CHARGE_TIMEOUT]
        |=> state_alert_cause[BIT_CHARGE_TIMEOUT])
        else $error("charge timeout alert missing");

    a_missing_alert : assert property ( // RL11
        @(posedge clock) disable iff (!resetn)
        $rose(battery_missing_fault) && state_en[BIT_MISSING]
        |=> alert_request && state_alert_cause[BIT_MISSING])
        else $error("missing battery alert missing");

    a_short_alert : assert property ( // RL12
        @(posedge clock) disable iff (!resetn)
        $rose(battery_short_fault) && state_en[BIT_SHORT]
        |=> alert_request && state_alert_cause[BIT_SHORT])
        else $error("short battery alert missing");

    a_safety_alert : assert property ( // RL14
        @(posedge clock) disable iff (!resetn)
        $rose(safety_limit_active) && status_en[BIT_SAFETY_LIMIT]
        |=> alert_request && status_alert_cause[BIT_SAFETY_LIMIT])
        else $error("safety limit alert missing");

    a_thermal_alert : assert property ( // RL15
        @(posedge clock) disable iff (!resetn)
        $rose(thermal_limit_active) && status_en[BIT_THERMAL_LIMIT]
        |=> status_alert_cause[BIT_THERMAL_LIMIT])
        else $error("thermal limit alert missing");

    a_uv_alert : assert property ( // RL16
        @(posedge clock) disable iff (!resetn)
        $rose(input_uv_loop_active) && status_en[BIT_INPUT_UV]
        |=> status_alert_cause[BIT_INPUT_UV])
        else $error("input undervoltage alert missing");

    a_icl_alert : assert property ( // RL17
        @(posedge clock) disable iff (!resetn)
        $rose(input_current_loop_active) && status_en[BIT_INPUT_CURRENT]
        |=> status_alert_cause[BIT_INPUT_CURRENT])
        else $error("input current alert missing");

    a_mask_suppress : assert property ( // RL18
        @(posedge clock) disable iff (!resetn)
        !$past(state_en[BIT_MISSING]) || $past(battery_missing_fault, 2)
        |-> !state_alert_cause[BIT_MISSING])
        else $error("alert without fresh enabled event");

    a_alert_has_cause : assert property ( // RL18
        @(posedge clock) disable iff (!resetn)
        alert_request == (|state_alert_cause || |status_alert_cause))
        else $error("alert request and causes disagree");

    a_reserved_zero : assert property ( // RL19
        @(posedge clock) disable iff (!resetn)
        state_en[BIT_RSVD_HI:BIT_RSVD_LO] == 2'b00
        && state_alert_cause[BIT_RSVD_HI:BIT_RSVD_LO] == 2'b00)
        else $error("reserved state bits not zero");

    a_held_once : assert property ( // RL18
        @(posedge clock) disable iff (!resetn)
        $past(resetn) && $past(suspended) && suspended
        |=> !state_alert_cause[BIT_SUSPENDED])
        else $error("held suspend level alerted twice");

    a_unmapped_miss : assert property ( // RL1
        @(posedge clock) disable iff (!resetn)
        (reg_write || reg_read) && reg_cmd != CMD_STATE_EN
        && reg_cmd != CMD_STATUS_EN
        |=> reg_miss)
        else $error("unmapped access not flagged");

    a_read_valid : assert property ( // RL13
        @(posedge clock) disable iff (!resetn)
        $past(resetn) |-> reg_rvalid == $past(reg_read))
        else $error("read valid not one cycle after read");

endmodule

// [dv/alert_host_model.sv]
// host-side model that collects alert request pulses from the device
`timescale 1ns/100ps
module alert_host_model
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // collection control
    input  wire logic        clear,
    // alert request from the device
    input  wire logic        alert_request,
    input  wire logic [12:0] state_alert_cause,
    input  wire logic [5:0]  status_alert_cause,
    // collected results
    output logic      [7:0]  pulses,
    output logic      [18:0] causes
);
    logic [7:0]  next_pulses;
    logic [18:0] next_causes;

    // counts each request outside a clear cycle and gathers the causes it carried
    always_comb
    begin
        next_pulses = pulses;
        next_causes = causes;
        if (clear)
        begin
            next_pulses = 8'h00;
            next_causes = 19'h0_0000;
        end
        else if (alert_request)
        begin
            next_pulses = pulses + 8'h01;
            next_causes = causes | {state_alert_cause, status_alert_cause};
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            pulses <= 8'h00;
            causes <= 19'h0_0000;
        end
        else
        begin
            pulses <= next_pulses;
            causes <= next_causes;
        end
    end
endmodule

// [dv/charger_alert_enable_masks_test.sv]
// testbench for the charger alert enable masks
`timescale 1ns/100ps
module charger_alert_enable_masks_test;
    import alert_mask_pkg::*;

    logic                clock      = 1'b0;
    logic                resetn     = 1'b0;
    logic [CMD_W-1:0]    reg_cmd    = 8'h00;
    logic                reg_write  = 1'b0;
    logic [DATA_W-1:0]   reg_wdata  = 16'h0000;
    logic                reg_read   = 1'b0;
    logic                clear      = 1'b0;
    logic [STATE_W-1:0]  ev_state   = 13'h0000;
    logic [STATUS_W-1:0] ev_status  = 6'h00;
    logic [DATA_W-1:0]   reg_rdata;
    logic                reg_rvalid;
    logic                reg_miss;
    logic                alert_request;
    logic [STATE_W-1:0]  state_cause;
    logic [STATUS_W-1:0] status_cause;
    logic [7:0]          pulses;
    logic [18:0]         causes;
    int                  errors     = 0;
    int                  n_checks   = 0;

    always #2.5 clock = ~clock;

    charger_alert_enable_masks dut
    (
        .clock                     (clock),
        .resetn                    (resetn),
        .reg_cmd                   (reg_cmd),
        .reg_write                 (reg_write),
        .reg_wdata                 (reg_wdata),
        .reg_read                  (reg_read),
        .reg_rdata                 (reg_rdata),
        .reg_rvalid                (reg_rvalid),
        .reg_miss                  (reg_miss),
        .detect_failed_fault       (ev_state[12]),
        .detect_testing            (ev_state[11]),
        .suspended                 (ev_state[8]),
        .precharge_phase           (ev_state[7]),
        .bulk_phase                (ev_state[6]),
        .temp_pause                (ev_state[5]),
        .cv_timeout_term           (ev_state[4]),
        .low_current_term          (ev_state[3]),
        .charge_timeout_fault      (ev_state[2]),
        .battery_missing_fault     (ev_state[1]),
        .battery_short_fault       (ev_state[0]),
        .safety_limit_active       (ev_status[5]),
        .thermal_limit_active      (ev_status[4]),
        .input_uv_loop_active      (ev_status[3]),
        .input_current_loop_active (ev_status[2]),
        .alert_request             (alert_request),
        .state_alert_cause         (state_cause),
        .status_alert_cause        (status_cause)
    );

    alert_host_model host
    (
        .clock              (clock),
        .resetn             (resetn),
        .clear              (clear),
        .alert_request      (alert_request),
        .state_alert_cause  (state_cause),
        .status_alert_cause (status_cause),
        .pulses             (pulses),
        .causes             (causes)
    );

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp_reg(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_alert(string what, logic [18:0] exp, logic [18:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(logic [7:0] cmd, logic [15:0] data);
        @(negedge clock);
        reg_cmd   = cmd;
        reg_wdata = data;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
    endtask

    // reads one word and compares data and the unmapped flag
    task automatic rd(logic [7:0] cmd, logic [15:0] exp, logic miss);
        int n;
        @(negedge clock);
        reg_cmd  = cmd;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        n = 0;
        while (reg_rvalid !== 1'b1 && n < 4)
        begin
            @(negedge clock);
            n++;
        end
        if (n == 4)
        begin
            errors++;
            $display("[FAIL] rvalid expected 1 seen %b", reg_rvalid);
            close_out();
        end
        else
        begin
            cmp_reg("rdata", exp, reg_rdata);
            cmp_reg("miss", {15'h0000, miss}, {15'h0000, reg_miss});
        end
    endtask

    // raises the events in m, holds them, then checks what the host saw
    task automatic run(logic [18:0] m, logic [18:0] exp_c, logic [7:0] exp_n);
        @(negedge clock);
        clear = 1'b1;
        @(negedge clock);
        clear = 1'b0;
        {ev_state, ev_status} = m;
        repeat (8) @(negedge clock);
        cmp_alert("pulses", {11'h000, exp_n}, {11'h000, pulses});
        cmp_alert("causes", exp_c, causes);
        {ev_state, ev_status} = 19'h0_0000;
        repeat (2) @(negedge clock);
    endtask

    // one event: alone enabled it fires once, masked it stays silent
    task automatic ev_check(logic st, int b);
        logic [18:0] m;
        m = 19'h0_0001 << (st ? b : b + 6);
        wr(CMD_STATE_EN, {3'b000, m[18:6]});
        wr(CMD_STATUS_EN, {10'h000, m[5:0]});
        run(m, m, 8'h01);
        wr(CMD_STATE_EN, {3'b000, ~m[18:6]});
        wr(CMD_STATUS_EN, {10'h000, ~m[5:0]});
        run(m, 19'h0_0000, 8'h00);
    endtask

    initial
    begin
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        rd(CMD_STATE_EN, 16'h0000, 1'b0);
        rd(CMD_STATUS_EN, 16'h0000, 1'b0);
        wr(CMD_STATE_EN, 16'hffff);
        rd(CMD_STATE_EN, 16'h19ff, 1'b0);
        wr(CMD_STATUS_EN, 16'hffff);
        rd(CMD_STATUS_EN, 16'h003f, 1'b0);
        rd(8'h10, 16'h0000, 1'b1);
        wr(8'h10, 16'hffff);
        cmp_reg("wmiss", 16'h0001, {15'h0000, reg_miss});
        rd(CMD_STATE_EN, 16'h19ff, 1'b0);
        run({13'h1fff, 6'h3f}, {13'h19ff, 6'h3c}, 8'h01);
        ev_check(1'b0, 12);
        ev_check(1'b0, 11);
        ev_check(1'b0, 8);
        ev_check(1'b0, 7);
        ev_check(1'b0, 6);
        ev_check(1'b0, 5);
        ev_check(1'b0, 4);
        ev_check(1'b0, 3);
        ev_check(1'b0, 2);
        ev_check(1'b0, 1);
        ev_check(1'b0, 0);
        ev_check(1'b1, 5);
        ev_check(1'b1, 4);
        ev_check(1'b1, 3);
        ev_check(1'b1, 2);
        close_out();
    end
endmodule
